// file: common/ccpts_params.svh
`ifndef CCPTS_PARAMS_SVH
`define CCPTS_PARAMS_SVH

// register indices (word addresses)
`define CCPTS_ADDR_TSEL      4'h0
`define CCPTS_ADDR_CON_BASE  4'h1
`define CCPTS_ADDR_CAP_BASE  4'h5
`define CCPTS_ADDR_STAT      4'h9
`define CCPTS_ADDR_MASK      4'ha
// field positions
`define CCPTS_TSEL_U4_LSB    6
`define CCPTS_TSEL_U3_LSB    4
`define CCPTS_TSEL_U2_LSB    2
`define CCPTS_TSEL_U1_LSB    0
// reset values
`define CCPTS_TSEL_FIELD_RST 2'h1
`define CCPTS_TSEL_RST       8'h55
`define CCPTS_CON_RST        8'h00
`define CCPTS_CAP_RST        4'h0
// mode codes
`define CCPTS_MODE_OFF       4'h0
`define CCPTS_MODE_PWM       4'hf
`define CCPTS_MODE_CAP_LO    4'h3
`define CCPTS_MODE_CAP_HI    4'h7
// control register masks
`define CCPTS_CON_WMASK      8'h9f
`define CCPTS_CAP_WMASK      8'h0f

`endif

// file: common/ccpts_pkg.sv
package ccpts_pkg;
  typedef enum logic [2:0] {
    CCPTS_SRC_NONE  = 3'h0,
    CCPTS_SRC_TIMER_ZERO  = 3'h1,
    CCPTS_SRC_CAP_A = 3'h2,
    CCPTS_SRC_CAP_B = 3'h3,
    CCPTS_SRC_CAP_C = 3'h4,
    CCPTS_SRC_PER_A = 3'h5,
    CCPTS_SRC_PER_B = 3'h6,
    CCPTS_SRC_PER_C = 3'h7
  } ccpts_src_type;

  typedef struct packed {
    logic       enable;
    logic       width_align;
    logic [3:0] mode;
  } ccpts_con_type;
endpackage

// file: rtl/ccpts_top.sv
// Operation
// - unit 4 timer field bits 7:6
// - unit 3 timer field bits 5:4
// - unit 2 timer field bits 3:2
// - unit 1 timer field bits 1:0
// - every field resets to binary 01
// - decode field by unit mode
// - unimplemented bits read as zero
// - 4-bit mode field selects operation
// - events set flag unless unit mode is off, may trigger conversion
`include "ccpts_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ccpts_top #(
  parameter int UNITS = 4
) (
  input  wire logic                CLK_SYS_I,
  input  wire logic                RESET_I,
  input  wire logic [3:0]          ADDR_I,
  input  wire logic [7:0]          WDATA_I,
  input  wire logic                WR_I,
  input  wire logic                RD_I,
  output logic      [7:0]          RDATA_O,
  input  wire logic [UNITS-1:0]    UNIT_EVENT_I,
  input  wire logic [UNITS-1:0]    UNIT_OUT_STATE_I,
  input  wire logic [UNITS-1:0]    CONV_TRIG_SEL_I,
  output logic [UNITS*3-1:0]       UNIT_SRC_O,
  output logic [UNITS*4-1:0]       UNIT_MODE_O,
  output logic [UNITS-1:0]         UNIT_ENABLE_O,
  output logic [UNITS-1:0]         UNIT_RESET_O,
  output logic [UNITS*4-1:0]       UNIT_CAP_SRC_O,
  output logic                     CONV_START_O,
  output logic                     IRQ_O
);

  logic [7:0]                 tsel_reg;
  logic [7:0]                 tsel_next;
  ccpts_pkg::ccpts_con_type   con_reg [UNITS];
  ccpts_pkg::ccpts_con_type   con_next [UNITS];
  logic [3:0]                 cap_reg [UNITS];
  logic [3:0]                 cap_next [UNITS];
  logic [UNITS-1:0]           stat_reg;
  logic [UNITS-1:0]           stat_next;
  logic [UNITS-1:0]           mask_reg;
  logic [UNITS-1:0]           mask_next;
  logic [7:0]                 rdata_reg;
  logic [7:0]                 rdata_next;
  logic [UNITS*3-1:0]         src_reg;
  logic [UNITS*3-1:0]         src_next;
  logic                       conv_reg;
  logic                       conv_next;

  function automatic ccpts_pkg::ccpts_src_type decode_src(input logic [1:0] code,
                                                          input logic [3:0] mode);
    ccpts_pkg::ccpts_src_type s;
    s = ccpts_pkg::CCPTS_SRC_NONE;
    if (mode == `CCPTS_MODE_PWM) begin
      case (code)
        2'h0: s = ccpts_pkg::CCPTS_SRC_NONE;
        2'h1: s = ccpts_pkg::CCPTS_SRC_PER_A;
        2'h2: s = ccpts_pkg::CCPTS_SRC_PER_B;
        2'h3: s = ccpts_pkg::CCPTS_SRC_PER_C;
        default: s = ccpts_pkg::CCPTS_SRC_NONE;
      endcase
    end else if (mode != `CCPTS_MODE_OFF) begin
      case (code)
        2'h0: s = ccpts_pkg::CCPTS_SRC_TIMER_ZERO;
        2'h1: s = ccpts_pkg::CCPTS_SRC_CAP_A;
        2'h2: s = ccpts_pkg::CCPTS_SRC_CAP_B;
        2'h3: s = ccpts_pkg::CCPTS_SRC_CAP_C;
        default: s = ccpts_pkg::CCPTS_SRC_NONE;
      endcase
    end
    return s;
  endfunction

  function automatic logic [7:0] con_read(input ccpts_pkg::ccpts_con_type c,
                                          input logic out_state);
    return {c.enable, 1'b0, out_state, c.width_align, c.mode};
  endfunction

  always_comb begin
    tsel_next  = tsel_reg;
    stat_next  = stat_reg;
    mask_next  = mask_reg;
    rdata_next = 8'h00;
    src_next   = src_reg;
    conv_next  = 1'b0;
    for (int u = 0; u < UNITS; u++) begin
      con_next[u] = con_reg[u];
      cap_next[u] = cap_reg[u];
    end
    if (WR_I) begin
      if (ADDR_I == `CCPTS_ADDR_TSEL) begin
        tsel_next[`CCPTS_TSEL_U4_LSB +: 2] = WDATA_I[`CCPTS_TSEL_U4_LSB +: 2];
        tsel_next[`CCPTS_TSEL_U3_LSB +: 2] = WDATA_I[`CCPTS_TSEL_U3_LSB +: 2];
        tsel_next[`CCPTS_TSEL_U2_LSB +: 2] = WDATA_I[`CCPTS_TSEL_U2_LSB +: 2];
        tsel_next[`CCPTS_TSEL_U1_LSB +: 2] = WDATA_I[`CCPTS_TSEL_U1_LSB +: 2];
      end
      if (ADDR_I == `CCPTS_ADDR_MASK) begin
        mask_next = WDATA_I[UNITS-1:0];
      end
      for (int u = 0; u < UNITS; u++) begin
        if (ADDR_I == `CCPTS_ADDR_CON_BASE + 4'(u)) begin
          con_next[u].enable      = WDATA_I[7];
          con_next[u].width_align = WDATA_I[4];
          con_next[u].mode        = WDATA_I[3:0];
        end
        if (ADDR_I == `CCPTS_ADDR_CAP_BASE + 4'(u)) begin
          cap_next[u] = WDATA_I[3:0];
        end
      end
    end
    // write-one clears, event wins
    if (WR_I && ADDR_I == `CCPTS_ADDR_STAT) begin
      stat_next = stat_next & ~WDATA_I[UNITS-1:0];
    end
    for (int u = 0; u < UNITS; u++) begin
      if (UNIT_EVENT_I[u] && con_reg[u].mode != `CCPTS_MODE_OFF) begin
        stat_next[u] = 1'b1;
        if (CONV_TRIG_SEL_I[u]) begin
          conv_next = 1'b1;
        end
      end
      src_next[u*3 +: 3] = decode_src(tsel_reg[u*2 +: 2], con_reg[u].mode);
    end
    if (RD_I) begin
      if (ADDR_I == `CCPTS_ADDR_TSEL) begin
        rdata_next = tsel_reg;
      end
      if (ADDR_I == `CCPTS_ADDR_STAT) begin
        rdata_next = 8'(stat_reg);
      end
      if (ADDR_I == `CCPTS_ADDR_MASK) begin
        rdata_next = 8'(mask_reg);
      end
      for (int u = 0; u < UNITS; u++) begin
        if (ADDR_I == `CCPTS_ADDR_CON_BASE + 4'(u)) begin
          rdata_next = con_read(con_reg[u], UNIT_OUT_STATE_I[u]);
        end
        if (ADDR_I == `CCPTS_ADDR_CAP_BASE + 4'(u)) begin
          rdata_next = {4'h0, cap_reg[u]};
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      tsel_reg  <= `CCPTS_TSEL_RST;
      stat_reg  <= '0;
      mask_reg  <= '0;
      rdata_reg <= 8'h00;
      src_reg   <= '0;
      conv_reg  <= 1'b0;
      for (int u = 0; u < UNITS; u++) begin
        con_reg[u] <= '0;
        cap_reg[u] <= `CCPTS_CAP_RST;
      end
    end else begin
      tsel_reg  <= tsel_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      rdata_reg <= rdata_next;
      src_reg   <= src_next;
      conv_reg  <= conv_next;
      for (int u = 0; u < UNITS; u++) begin
        con_reg[u] <= con_next[u];
        cap_reg[u] <= cap_next[u];
      end
    end
  end

  always_comb begin
    for (int u = 0; u < UNITS; u++) begin
      UNIT_MODE_O[u*4 +: 4]    = con_reg[u].mode;
      UNIT_ENABLE_O[u]         = con_reg[u].enable;
      UNIT_RESET_O[u]          = (con_reg[u].mode == `CCPTS_MODE_OFF);
      UNIT_CAP_SRC_O[u*4 +: 4] = cap_reg[u];
    end
  end

  assign RDATA_O      = rdata_reg;
  assign UNIT_SRC_O   = src_reg;
  assign CONV_START_O = conv_reg;
  assign IRQ_O        = |(stat_reg & mask_reg);

endmodule

`default_nettype wire

// file: verif/ccpts_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ccpts_chk #(
  parameter int UNITS = 4
) (
  input wire logic               CLK_SYS_I,
  input wire logic               RESET_I,
  input wire logic [3:0]         ADDR_I,
  input wire logic [7:0]         WDATA_I,
  input wire logic               WR_I,
  input wire logic               RD_I,
  input wire logic [7:0]         RDATA_O,
  input wire logic [UNITS-1:0]   UNIT_EVENT_I,
  input wire logic [UNITS-1:0]   CONV_TRIG_SEL_I,
  input wire logic [UNITS*3-1:0] UNIT_SRC_O,
  input wire logic [UNITS*4-1:0] UNIT_MODE_O,
  input wire logic [UNITS-1:0]   UNIT_RESET_O,
  input wire logic               CONV_START_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);
  sequence s_wr_rd;
    WR_I && ADDR_I == 4'h0 ##1 !WR_I ##1 RD_I && ADDR_I == 4'h0;
  endsequence
  a_tsel_readback: assert property (s_wr_rd |=> RDATA_O == $past(WDATA_I, 3))
    else $error("tsel readback");
  a_cap_upper: assert property (RD_I && ADDR_I inside {[4'h5:4'h8]} |=> RDATA_O[7:4] == 4'h0)
    else $error("cap upper");
  a_con_bit6: assert property (RD_I && ADDR_I inside {[4'h1:4'h4]} |=> !RDATA_O[6])
    else $error("con bit6");
  a_unmapped_zero: assert property (RD_I && ADDR_I > 4'ha |=> RDATA_O == 8'h00)
    else $error("unmapped read");
  a_off_reset: assert property (UNIT_RESET_O[0] == (UNIT_MODE_O[3:0] == 4'h0))
    else $error("unit reset");
  a_pwm_timer: assert property ($past(UNIT_MODE_O[3:0]) == 4'hf |->
    UNIT_SRC_O[2:0] inside {3'h0, [3'h5:3'h7]}) else $error("pwm src");
  a_cap_timer: assert property ($past(UNIT_MODE_O[3:0]) inside {[4'h1:4'he]} |->
    UNIT_SRC_O[2:0] inside {[3'h1:3'h4]}) else $error("cap src");
  a_conv_start: assert property
    (CONV_START_O == |$past(UNIT_EVENT_I & CONV_TRIG_SEL_I & ~UNIT_RESET_O)) else $error("conv");
endmodule
bind ccpts_top ccpts_chk #(.UNITS(UNITS)) u_chk (.CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .UNIT_EVENT_I(UNIT_EVENT_I), .CONV_TRIG_SEL_I(CONV_TRIG_SEL_I), .UNIT_SRC_O(UNIT_SRC_O),
  .UNIT_MODE_O(UNIT_MODE_O), .UNIT_RESET_O(UNIT_RESET_O), .CONV_START_O(CONV_START_O));
`default_nettype wire

// file: verif/ccpts_unit_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccpts_unit_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] fire_i,
  output logic      [3:0] event_o = 4'h0,
  output logic      [3:0] state_o = 4'h0,
  output logic      [3:0] trig_o
);
  assign trig_o = 4'h5;
  always @(posedge clk_i) begin
    event_o <= fire_i;
    state_o <= state_o ^ fire_i;
  end
endmodule
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  logic        clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, conv, irq;
  logic [3:0]  addr = 4'h0, fire = 4'h0, ev, ost, trig;
  logic [7:0]  wdata = 8'h0, rdata, ts, d, c [4];
  logic [11:0] src;
  logic [3:0]  en;
  logic [15:0] capo;
  logic [31:0] seed = 32'he;
  int          bad_count = 0, tests_run = 0;
  ccpts_top DUT (.CLK_SYS_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .UNIT_EVENT_I(ev), .UNIT_OUT_STATE_I(ost),
    .CONV_TRIG_SEL_I(trig), .UNIT_SRC_O(src), .UNIT_MODE_O(), .UNIT_ENABLE_O(en),
    .UNIT_RESET_O(), .UNIT_CAP_SRC_O(capo), .CONV_START_O(conv), .IRQ_O(irq));
  ccpts_unit_model u_far (.clk_i(clk), .fire_i(fire), .event_o(ev), .state_o(ost),
    .trig_o(trig));
  initial forever #2 clk = ~clk;
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [2:0] exp_src(logic [1:0] f, logic [3:0] m);
    if (m == 4'h0) return 3'h0;
    if (m == 4'hf) return (f == 2'h0) ? 3'h0 : {1'h0, f} + 3'h4;
    return {1'h0, f} + 3'h1;
  endfunction
  task automatic wrt(logic [3:0] a, logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rdc(string n, logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 `CHK(n, e, rdata)
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    rdc("tsel_rst", 4'h0, 8'h55);
    rdc("cap_rst", 4'h5, 8'h00);
    rdc("unmapped", 4'hb, 8'h00);
    `CHK("src_rst", 12'h000, src)
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      ts = (i == 0) ? 8'he4 : xs();
      wrt(4'h0, ts);
      if (i < 4) rdc("tsel_now", 4'h0, ts);
      for (int u = 0; u < 4; u++) begin
        c[u] = (i < 2) ? {4'h8, i == 0 ? 4'hf : 4'h3} : xs();
        wrt(4'(u + 1), c[u]);
      end
      settle();
      for (int u = 0; u < 4; u++)
        `CHK("src", exp_src(ts[2*u +: 2], c[u][3:0]), src[3*u +: 3])
      `CHK("en", {c[3][7], c[2][7], c[1][7], c[0][7]}, en)
      rdc("tsel", 4'h0, ts);
      d = xs();
      rdc("ctl", 4'(d[1:0] + 1), {c[d[1:0]][7], 1'h0, ost[d[1:0]], c[d[1:0]][4:0]});
      wrt(4'(d[1:0] + 5), ts);
      settle();
      `CHK("capsrc", ts[3:0], capo[4*d[1:0] +: 4])
      rdc("cap", 4'(d[1:0] + 5), {4'h0, ts[3:0]});
    end
    $display("test random done");
    wrt(4'h1, 8'h83);
    wrt(4'h2, 8'h00);
    wrt(4'ha, 8'h00);
    @(posedge clk) fire <= 4'h3;
    @(posedge clk) fire <= 4'h0;
    @(posedge clk);
    #1 `CHK("conv", 1'h1, conv)
    rdc("stat", 4'h9, 8'h01);
    `CHK("irq_mask", 1'h0, irq)
    wrt(4'ha, 8'h01);
    settle();
    `CHK("irq_on", 1'h1, irq)
    wrt(4'h9, 8'h01);
    settle();
    `CHK("irq_clr", 1'h0, irq)
    $display("test events done");
    stop_test();
  end
endmodule
`default_nettype wire
